/* File: hw/srxis_pkg.sv */
// Purpose: constants for the receive-side serial interrupt sources
// Assumes: apb register map, 32-bit aligned words
// Notes:   offsets are byte addresses
package srxis_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_CMD_STATUS_REG_OFF = 8'h00;
  localparam logic [7:0] RX_INT_CTRL_REG_OFF = 8'h04;
  localparam logic [7:0] DAISY_CHAIN_CTRL_REG_OFF = 8'h08;
  localparam logic [7:0] CFG_OFF  = 8'h0c;
  localparam logic [7:0] STAT_OFF = 8'h10;
  localparam logic [7:0] VEC_OFF  = 8'h14;
  // ----------------------------------------------------------------
  // fields and values
  // ----------------------------------------------------------------
  localparam int HUNT_BIT  = 7;
  localparam int IDLE_BIT  = 6;
  localparam int BRK_BIT   = 5;
  localparam int BND_BIT   = 2;
  localparam int PAR_BIT   = 1;
  localparam int OVR_BIT   = 0;
  localparam logic [3:0] CMD_SEL_LEVEL = 4'h6;
  localparam int NTYPES    = 6;
  localparam logic [1:0] ACK_EDGE   = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_RSVD   = 2'h2;
  localparam logic [1:0] ACK_DOUBLE = 2'h3;
  localparam logic [7:0] RX_INT_CTRL_REG_RST   = 8'h00;
  localparam logic [7:0] VEC_RST    = 8'h00;
  typedef enum logic [1:0] {
    ACK_IDLE  = 2'b00,
    ACK_FIRST = 2'b01,
    ACK_RESP  = 2'b10
  } srxis_ack_type;
endpackage

/* File: hw/srxis_top.sv */
// Purpose: receive status / data interrupt sources with priority chain
// Assumes: host strobes are synchronous to pclk, active-low levels
// Notes:   transmit, pin and misc types arrive as request inputs
//
// Behaviour
// - edge style on muxed bus: low ack at address strobe rise ignores address
// - edge style on plain bus: ack level captured at each read or data strobe
// - edge style with data strobe: direction ignored when ack sampled low
// - wait output asserted only in acknowledge cycles, never in register cycles
// - ready output asserted later in acknowledge cycles than in reads; never asserted in reads here
// - priority: rx status, rx data, tx status, tx data, pin, misc
// - each type owns one enable, one pending and one under-service bit
// - hunt exit flag bit 7 rises on sync or flag, may set pending
// - idle flag bit 6 rises after run of ones; avoid arming in async
// - break/abort flag bit 5 rises on break or abort, may set pending
// - armed read of boundary-tagged character sets status pending
// - armed read of parity or queued-abort character sets status pending
// - armed read of overrun-tagged character sets status pending
// - armed set bit stays latched until software writes one there
// - idle and async break clear only after unlatch and condition end
// - six arm bits in low byte of control; unarmed source never pends
// - arms of hunt, idle, break leave status alone; others change it
// - data pending when character arrives with count equal to level
// - data pending when boundary character written below level
// - queue reads never clear data pending or under-service bits
// - boundary read latches status; next status read releases it
// - style field: 00 edge, 01 single pulse, 11 double, 10 reserved
// - ack with chain in high sets top under-service and drives vector
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module srxis_top #(
  parameter int QDEPTH_W = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        int_acknowledge_pin_n,
  input  wire logic        address_strobe_pin_n,
  input  wire logic        data_strobe_pin_n,
  input  wire logic        read_strobe_pin_n,
  input  wire logic        read_write_select,
  input  wire logic        chain_in_pin,
  output logic             chain_out_pin,
  output logic             wait_ready_pin_n,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  output logic             cycle_is_write,
  output logic             cycle_is_read,
  input  wire logic        hunt_exit_evt,
  input  wire logic        idle_line_level,
  input  wire logic        break_level,
  input  wire logic        abort_evt,
  input  wire logic        async_mode,
  input  wire logic        bitframe_mode,
  input  wire logic        rx_write,
  input  wire logic        rx_write_bound,
  input  wire logic [QDEPTH_W-1:0] rx_count,
  input  wire logic        rx_read,
  input  wire logic        rx_read_bound,
  input  wire logic        rx_read_parity,
  input  wire logic        rx_read_abort,
  input  wire logic        rx_read_overrun,
  input  wire logic [3:0]  low_type_req
);
  initial begin
    if (QDEPTH_W < 1 || QDEPTH_W > 8) begin
      $error("QDEPTH_W out of range");
    end
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  bound_hold;
    logic [7:0]  arm;
    logic [7:0]  level;
    logic        sel_level;
    logic [5:0]  ie;
    logic [5:0]  ip;
    logic [5:0]  int_under_service_bit;
    logic [1:0]  ack_style;
    logic        muxed;
    logic        wait_mode;
    logic        queued_abort;
    logic [7:0]  vector;
    logic        as_d;
    logic        ds_d;
    logic        ia_d;
    logic        ack_cap;
    srxis_pkg::srxis_ack_type ack;
    logic        frozen;
    logic [1:0]  unl;
    logic [1:0]  rdy_cnt;
    logic [7:0]  ad;
    logic        ad_oe;
    logic        rd;
    logic        wr;
    logic [31:0] prdata;
  } srxis_state_type;
  srxis_state_type s_r;
  srxis_state_type s_nxt;
  function automatic logic [5:0] top_one(input logic [5:0] v);
    logic [5:0] o;
    o = 6'h00;
    for (int i = srxis_pkg::NTYPES - 1; i >= 0; i--) begin
      if (v[i]) begin
        o = 6'h00;
        o[i] = 1'b1;
      end
    end
    return o;
  endfunction
  logic        acc;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [5:0]  req;
  logic [5:0]  blocked;
  logic [5:0]  grant;
  logic        requesting;
  logic        strobe_fall;
  logic        ack_start;
  logic        ack_go;
  logic [7:0]  setv;
  logic [7:0]  clr_w;
  logic [1:0]  line_on;
  assign acc    = psel & penable;
  assign mapped = paddr <= srxis_pkg::VEC_OFF && paddr[1:0] == 2'b00;
  assign wr_en  = acc & pwrite & mapped;
  assign rd_en  = acc & ~pwrite & mapped;
  assign line_on = {async_mode & break_level, idle_line_level};
  // ----------------------------------------------------------------
  // priority chain
  // ----------------------------------------------------------------
  // bit 0 is rx status; a lower bit outranks a higher bit
  always_comb begin
    blocked = 6'h00;
    for (int i = 1; i < srxis_pkg::NTYPES; i++) begin
      blocked[i] = blocked[i-1] | s_r.int_under_service_bit[i-1];
    end
  end
  assign req        = s_r.ip & s_r.ie & ~blocked & ~s_r.int_under_service_bit;
  assign requesting = |req;
  assign grant      = top_one(req);
  assign strobe_fall = (s_r.ds_d & ~data_strobe_pin_n) | (s_r.ds_d & ~read_strobe_pin_n);
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    setv = 8'h00;
    clr_w = 8'h00;
    ack_start = 1'b0;
    ack_go = 1'b0;
    s_nxt.as_d = address_strobe_pin_n;
    s_nxt.ds_d = data_strobe_pin_n & read_strobe_pin_n;
    s_nxt.ia_d = int_acknowledge_pin_n;
    s_nxt.rd = 1'b0;
    s_nxt.wr = 1'b0;
    // acknowledge capture by style
    case (s_r.ack_style)
      srxis_pkg::ACK_EDGE: begin
        if (s_r.muxed && !s_r.as_d ^ !address_strobe_pin_n && address_strobe_pin_n) begin
          s_nxt.ack_cap = ~int_acknowledge_pin_n;
        end
        if (!s_r.muxed && strobe_fall) begin
          s_nxt.ack_cap = ~int_acknowledge_pin_n;
        end
        ack_start = strobe_fall && (s_r.muxed ? s_r.ack_cap : ~int_acknowledge_pin_n);
        // address and direction disregarded in acknowledge cycles
        if (strobe_fall && !ack_start) begin
          s_nxt.rd = read_write_select;
          s_nxt.wr = ~read_write_select;
        end
      end
      srxis_pkg::ACK_SINGLE: ack_start = s_r.ia_d & ~int_acknowledge_pin_n;
      srxis_pkg::ACK_DOUBLE: begin
        if (s_r.ia_d && !int_acknowledge_pin_n) begin
          if (s_r.ack == srxis_pkg::ACK_IDLE) begin
            s_nxt.ack = srxis_pkg::ACK_FIRST;
            s_nxt.frozen = requesting;
          end else begin
            ack_start = 1'b1;
          end
        end
      end
      default: ack_start = 1'b0; // reserved style answers nothing
    endcase
    if (ack_start) begin
      s_nxt.frozen = requesting;
      if (chain_in_pin && requesting) begin
        ack_go = 1'b1;
        s_nxt.int_under_service_bit = s_r.int_under_service_bit | grant;
        for (int i = 0; i < srxis_pkg::NTYPES; i++) begin
          if (grant[i]) begin
            s_nxt.ad = {s_r.vector[7:3], 3'(i)};
          end
        end
        s_nxt.ad_oe = 1'b1;
        s_nxt.ack = srxis_pkg::ACK_RESP;
        s_nxt.rdy_cnt = 2'h3;
      end else begin
        s_nxt.ack = srxis_pkg::ACK_IDLE;
      end
    end
    if (s_r.ack == srxis_pkg::ACK_RESP && s_r.rdy_cnt != 2'h0) begin
      s_nxt.rdy_cnt = s_r.rdy_cnt - 2'h1;
    end
    if ((s_r.ack == srxis_pkg::ACK_IDLE ||
         (s_r.ack == srxis_pkg::ACK_RESP && s_r.rdy_cnt == 2'h0)) &&
        data_strobe_pin_n && read_strobe_pin_n && int_acknowledge_pin_n) begin
      s_nxt.ack = srxis_pkg::ACK_IDLE;
      s_nxt.ad_oe = 1'b0;
      s_nxt.frozen = 1'b0;
    end
    // ---- status sources
    setv[srxis_pkg::HUNT_BIT] = hunt_exit_evt;
    setv[srxis_pkg::IDLE_BIT] = idle_line_level;
    setv[srxis_pkg::BRK_BIT]  = (async_mode & break_level) | (bitframe_mode & abort_evt);
    setv[srxis_pkg::BND_BIT]  = rx_read & rx_read_bound & s_r.arm[srxis_pkg::BND_BIT];
    setv[srxis_pkg::PAR_BIT]  = rx_read & s_r.arm[srxis_pkg::PAR_BIT] & (rx_read_parity |
                                (bitframe_mode & s_r.queued_abort & rx_read_abort));
    setv[srxis_pkg::OVR_BIT]  = rx_read & rx_read_overrun & s_r.arm[srxis_pkg::OVR_BIT];
    if (wr_en && paddr == srxis_pkg::RX_CMD_STATUS_REG_OFF) begin
      clr_w = pwdata[7:0] & s_r.status;
      if (pwdata[15:12] == srxis_pkg::CMD_SEL_LEVEL) begin
        s_nxt.sel_level = 1'b1;
      end
    end
    for (int b = 0; b < 8; b++) begin
      if (setv[b]) begin
        s_nxt.status[b] = 1'b1;
      end else if (clr_w[b]) begin
        s_nxt.status[b] = 1'b0;
      end
    end
    // a line condition still present keeps its bit until it ends
    for (int u = 0; u < 2; u++) begin
      if (clr_w[srxis_pkg::IDLE_BIT - u] && line_on[u]) begin
        s_nxt.unl[u] = 1'b1;
      end else if (s_r.unl[u] && !line_on[u] && !setv[srxis_pkg::IDLE_BIT - u]) begin
        s_nxt.status[srxis_pkg::IDLE_BIT - u] = 1'b0;
        s_nxt.unl[u] = 1'b0;
      end
    end
    if (rx_read && rx_read_bound) begin
      s_nxt.bound_hold = 8'h01;
    end else if (rd_en && paddr == srxis_pkg::RX_CMD_STATUS_REG_OFF) begin
      s_nxt.bound_hold = 8'h00;
    end
    // pending sets: only armed rising status raises rx status pending
    if ((setv & ~s_r.status & s_r.arm) != 8'h00) begin
      s_nxt.ip[0] = 1'b1;
    end
    if (rx_write && (rx_count == QDEPTH_W'(s_r.level) ||
        (rx_write_bound && rx_count < QDEPTH_W'(s_r.level)))) begin
      s_nxt.ip[1] = 1'b1;
    end
    for (int t = 2; t < srxis_pkg::NTYPES; t++) begin
      if (low_type_req[t-2]) begin
        s_nxt.ip[t] = 1'b1;
      end
    end
    // ---- register writes (hardware sets win over clears)
    if (wr_en) begin
      case (paddr)
        srxis_pkg::RX_INT_CTRL_REG_OFF: begin
          s_nxt.arm = pwdata[7:0];
          if (s_r.sel_level) begin
            s_nxt.level = pwdata[15:8];
            s_nxt.sel_level = 1'b0;
          end
        end
        srxis_pkg::DAISY_CHAIN_CTRL_REG_OFF: begin
          for (int t = 0; t < srxis_pkg::NTYPES; t++) begin
            if (pwdata[t] && !(s_nxt.ip[t] && !s_r.ip[t])) begin
              s_nxt.ip[t] = 1'b0;
            end
            if (pwdata[8+t] && !(ack_go && grant[t])) begin
              s_nxt.int_under_service_bit[t] = 1'b0;
            end
          end
          s_nxt.ie = pwdata[21:16];
        end
        srxis_pkg::CFG_OFF: begin
          s_nxt.ack_style    = pwdata[1:0];
          s_nxt.muxed        = pwdata[2];
          s_nxt.wait_mode    = pwdata[3];
          s_nxt.queued_abort = pwdata[8];
        end
        srxis_pkg::VEC_OFF: begin
          s_nxt.vector = pwdata[7:0];
        end
        default: s_nxt.vector = s_r.vector;
      endcase
    end
    s_nxt.prdata = 32'h0;
    case (paddr)
      srxis_pkg::RX_CMD_STATUS_REG_OFF: s_nxt.prdata = {23'h0, s_r.bound_hold[0], s_r.status};
      srxis_pkg::RX_INT_CTRL_REG_OFF: s_nxt.prdata = {16'h0, s_r.level, s_r.arm};
      srxis_pkg::DAISY_CHAIN_CTRL_REG_OFF: s_nxt.prdata = {10'h0, s_r.ie, 2'h0, s_r.int_under_service_bit, 2'h0, s_r.ip};
      srxis_pkg::CFG_OFF:  s_nxt.prdata = {23'h0, s_r.queued_abort, 4'h0, s_r.wait_mode,
                                           s_r.muxed, s_r.ack_style};
      srxis_pkg::STAT_OFF: s_nxt.prdata = {29'h0, s_r.ack, s_r.frozen};
      srxis_pkg::VEC_OFF:  s_nxt.prdata = {24'h0, s_r.vector};
      default:             s_nxt.prdata = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.as_d <= 1'b1;
      s_r.ds_d <= 1'b1;
      s_r.ia_d <= 1'b1;
      s_r.arm <= srxis_pkg::RX_INT_CTRL_REG_RST;
      s_r.vector <= srxis_pkg::VEC_RST;
      s_r.ack <= srxis_pkg::ACK_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // apb answers in the access cycle; read data held from setup
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = s_r.prdata;
  assign ad_out  = s_r.ad;
  assign ad_oe   = s_r.ad_oe;
  assign cycle_is_read  = s_r.rd;
  assign cycle_is_write = s_r.wr;
  // chain out forced low while requesting or frozen in an acknowledge
  assign chain_out_pin = chain_in_pin & ~requesting & ~s_r.frozen & ~(|s_r.int_under_service_bit);
  // wait style: low only while the vector is settling; ready: low once valid
  assign wait_ready_pin_n = (s_r.ack != srxis_pkg::ACK_RESP) ? 1'b1 :
                            (s_r.wait_mode ? (s_r.rdy_cnt == 2'h0) :
                             (s_r.rdy_cnt != 2'h0));
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_wait_only_ack;
    @(posedge pclk) disable iff (!presetn)
    (s_r.ack != srxis_pkg::ACK_RESP) |-> wait_ready_pin_n;
  endproperty
  a_wait_only_ack: assert property (p_wait_only_ack) else $error("wait outside ack");
  sequence s_ack_resp;
    s_r.ack == srxis_pkg::ACK_RESP && s_r.rdy_cnt == 2'h3;
  endsequence
  property p_ready_late;
    @(posedge pclk) disable iff (!presetn)
    (s_ack_resp and !s_r.wait_mode) |-> wait_ready_pin_n [*3];
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too early");
  property p_prio;
    @(posedge pclk) disable iff (!presetn)
    req[0] |-> grant == 6'h01;
  endproperty
  a_prio: assert property (p_prio) else $error("rx status not first");
  property p_unarmed;
    @(posedge pclk) disable iff (!presetn)
    (!s_r.ip[0] && s_r.arm == 8'h00 && !(wr_en && paddr == srxis_pkg::DAISY_CHAIN_CTRL_REG_OFF))
      |=> !s_r.ip[0];
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed source pended");
  property p_latched;
    @(posedge pclk) disable iff (!presetn)
    (s_r.status[srxis_pkg::OVR_BIT] && !(wr_en && paddr == srxis_pkg::RX_CMD_STATUS_REG_OFF))
      |=> s_r.status[srxis_pkg::OVR_BIT];
  endproperty
  a_latched: assert property (p_latched) else $error("status not latched");
  property p_rd_level;
    @(posedge pclk) disable iff (!presetn)
    (rx_write && rx_count == QDEPTH_W'(s_r.level)) |=> s_r.ip[1];
  endproperty
  a_rd_level: assert property (p_rd_level) else $error("rx data pending missed");
  property p_read_keeps;
    @(posedge pclk) disable iff (!presetn)
    (s_r.ip[1] && !(wr_en && paddr == srxis_pkg::DAISY_CHAIN_CTRL_REG_OFF)) |=> s_r.ip[1];
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("data pending lost");
  property p_ack_ius;
    @(posedge pclk) disable iff (!presetn)
    ack_go |=> (s_r.int_under_service_bit & $past(grant)) != 6'h00 && s_r.ad_oe;
  endproperty
  a_ack_ius: assert property (p_ack_ius) else $error("ack did not set ius");
endmodule

/* File: tb/srxis_host_model.sv */
// Purpose: host bus side issuing register and acknowledge strobe cycles
// Assumes: strobes active low, every change just after a rising edge
// Notes:   released strobes return high, their pulled-up idle level
`timescale 1ns/1ps
module srxis_host_model (
  input  wire logic       pclk,
  input  wire logic       wait_ready_pin_n,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  input  wire logic       cycle_is_read,
  input  wire logic       cycle_is_write,
  output logic            ack_n,
  output logic            as_n,
  output logic            ds_n,
  output logic            rd_n,
  output logic            rws
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  initial begin
    ack_n = 1'h1;
    as_n = 1'h1;
    ds_n = 1'h1;
    rd_n = 1'h1;
    rws = 1'h1;
  end
  // r = {saw write, saw read, saw wait, answered, vector}
  task automatic cyc(input logic ak, input logic [1:0] st, input logic mx,
                     input logic rs, input logic rw, output logic [11:0] r);
    r = 12'h000;
    if (ak && st == 2'h3) begin  // first pulse only freezes state
      ack_n <= 1'h0;
      @(posedge pclk);
      ack_n <= 1'h1;
      @(posedge pclk);
    end
    ack_n <= ~ak;
    as_n <= ~mx;
    @(posedge pclk);
    as_n <= 1'h1;
    if (mx) @(posedge pclk);
    if (!ak || st == 2'h0) begin  // edge style: the strobe carries the cycle
      rws <= rw;
      if (rs) rd_n <= 1'h0;
      else ds_n <= 1'h0;
    end
    repeat (8) begin
      @(posedge pclk);
      if (ad_oe === 1'h1) r[8:0] = {1'h1, ad_out};
      if (wait_ready_pin_n === 1'h0) r[9] = 1'h1;
      if (cycle_is_read === 1'h1) r[10] = 1'h1;
      if (cycle_is_write === 1'h1) r[11] = 1'h1;
    end
    ack_n <= 1'h1;
    ds_n <= 1'h1;
    rd_n <= 1'h1;
    rws <= 1'h1;
    repeat (2) @(posedge pclk);
  endtask
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the receive interrupt sources
// Assumes: apb master on pclk, host strobes from the bus model
// Notes:   vector base 8'ha8, so the low three bits give the type
`timescale 1ns/1ps
`define CHK(nm, x, g) begin total_checks++; if ((g) !== (x)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, x, g); end end
module tb;
  localparam logic [7:0] A_ST = srxis_pkg::RX_CMD_STATUS_REG_OFF;
  localparam logic [7:0] A_IC = srxis_pkg::RX_INT_CTRL_REG_OFF;
  localparam logic [7:0] A_DC = srxis_pkg::DAISY_CHAIN_CTRL_REG_OFF;
  localparam logic [7:0] A_CF = srxis_pkg::CFG_OFF;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, chain_in, chain_out;
  logic        wrdy_n, ad_oe, c_rd, c_wr, ack_n, as_n, ds_n, rd_n, rws, idle_lvl, brk_lvl;
  logic        async_m, bitf_m;
  logic [7:0]  paddr, ad_out;
  logic [31:0] pwdata, prdata, q;
  logic [12:0] ev;
  logic [11:0] r;
  logic [5:0]  cnt;
  int          total_checks, n_mismatch, cyc_cnt;
  // event masks: hunt, abort, bound read, parity read, abort-tag read, overrun read
  logic [12:0] sev [6] = '{13'h001, 13'h002, 13'h030, 13'h050, 13'h090, 13'h110};
  int          sbit [6] = '{7, 5, 2, 1, 1, 0};

  srxis_top srxis_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .int_acknowledge_pin_n(ack_n), .address_strobe_pin_n(as_n), .data_strobe_pin_n(ds_n),
    .read_strobe_pin_n(rd_n), .read_write_select(rws), .chain_in_pin(chain_in),
    .chain_out_pin(chain_out), .wait_ready_pin_n(wrdy_n), .ad_out, .ad_oe,
    .cycle_is_write(c_wr), .cycle_is_read(c_rd), .hunt_exit_evt(ev[0]),
    .idle_line_level(idle_lvl), .break_level(brk_lvl), .abort_evt(ev[1]),
    .async_mode(async_m), .bitframe_mode(bitf_m), .rx_write(ev[2]), .rx_write_bound(ev[3]),
    .rx_count(cnt), .rx_read(ev[4]), .rx_read_bound(ev[5]), .rx_read_parity(ev[6]),
    .rx_read_abort(ev[7]), .rx_read_overrun(ev[8]), .low_type_req(ev[12:9])
  );
  srxis_host_model srxis_host_model_inst (
    .pclk, .wait_ready_pin_n(wrdy_n), .ad_out, .ad_oe, .cycle_is_read(c_rd),
    .cycle_is_write(c_wr), .ack_n, .as_n, .ds_n, .rd_n, .rws
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    `CHK("pready", 1'h1, pready)
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [12:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 13'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic bit_is(input logic [7:0] a, input int b, input logic x, input string nm);
    apb(1'h0, a, 32'h0);
    `CHK(nm, x, q[b])
  endtask
  task automatic ack_case(input logic [31:0] cf, input logic [12:0] m, input logic [1:0] st,
                          input logic mx, input logic rs, input logic [7:0] v);
    apb(1'h1, A_CF, cf);
    if (m != 13'h0) pulse(m);
    srxis_host_model_inst.cyc(1'h1, st, mx, rs, 1'h0, r);
    `CHK("vector", v, r[7:0])
    `CHK("wait seen", 1'h1, r[9])
    `CHK("write seen", 1'h0, r[11])
    bit_is(A_DC, 8 + v[2:0], 1'h1, "under service");
    apb(1'h1, A_DC, 32'h003f_0000 | (32'h101 << v[2:0]));
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, timeout and tests
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, idle_lvl, brk_lvl, async_m} = 7'h00;
    {bitf_m, chain_in} = 2'h3;
    {paddr, pwdata, ev, cnt} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    bit_is(A_IC, 8, 1'h0, "level reset");
    `CHK("control reset", 32'h0, q)
    bit_is(A_DC, 0, 1'h0, "chain reset");
    `CHK("chain reg reset", 32'h0, q)
    apb(1'h0, 8'h20, 32'h0);
    `CHK("unmapped error", 1'h1, e)
    apb(1'h1, A_IC, 32'h0500);
    bit_is(A_IC, 8, 1'h0, "level without select");
    apb(1'h1, A_ST, 32'h6000); // select level command
    apb(1'h1, A_IC, 32'h0300); // level four minus one
    bit_is(A_IC, 8, 1'h1, "level");
    `CHK("level value", 32'h0300, q)
    $display("test registers done");
    cnt <= 6'h02;
    pulse(13'h004);
    bit_is(A_DC, 1, 1'h0, "data pend below level");
    cnt <= 6'h03;
    pulse(13'h004);
    bit_is(A_DC, 1, 1'h1, "data pend at level");
    pulse(13'h010);
    bit_is(A_DC, 1, 1'h1, "data pend after read");
    apb(1'h1, A_DC, 32'h2);
    cnt <= 6'h01;
    pulse(13'h00c);
    bit_is(A_DC, 1, 1'h1, "data pend boundary");
    apb(1'h1, A_DC, 32'h2);
    bit_is(A_DC, 1, 1'h0, "data pend cleared");
    $display("test receive data done");
    apb(1'h1, A_CF, 32'h100);
    for (int k = 0; k < 6; k++) begin
      apb(1'h1, A_IC, 32'h0300 | (32'h1 << sbit[k]));
      pulse(sev[k]);
      bit_is(A_ST, sbit[k], 1'h1, "status set");
      if (k == 2) begin
        `CHK("boundary hold", 1'h1, q[8])
        bit_is(A_ST, 8, 1'h0, "hold released");
      end
      bit_is(A_DC, 0, 1'h1, "status pend armed");
      apb(1'h1, A_ST, 32'h1 << sbit[k]);
      bit_is(A_ST, sbit[k], 1'h0, "status unlatched");
      apb(1'h1, A_DC, 32'h1);
      apb(1'h1, A_IC, 32'h0300);
      pulse(sev[k]);
      bit_is(A_DC, 0, 1'h0, "status pend unarmed");
      apb(1'h1, A_ST, 32'h1 << sbit[k]);
    end
    apb(1'h1, A_IC, 32'h0340);
    idle_lvl <= 1'h1;
    repeat (2) @(posedge pclk);
    bit_is(A_ST, 6, 1'h1, "idle set");
    apb(1'h1, A_ST, 32'h40);
    bit_is(A_ST, 6, 1'h1, "idle held while idle");
    idle_lvl <= 1'h0;
    repeat (2) @(posedge pclk);
    bit_is(A_ST, 6, 1'h0, "idle released");
    async_m <= 1'h1;
    apb(1'h1, A_IC, 32'h0320);
    brk_lvl <= 1'h1;
    repeat (2) @(posedge pclk);
    apb(1'h1, A_ST, 32'h20);
    bit_is(A_ST, 5, 1'h1, "break held while break");
    brk_lvl <= 1'h0;
    repeat (2) @(posedge pclk);
    bit_is(A_ST, 5, 1'h0, "break released");
    async_m <= 1'h0;
    apb(1'h1, A_DC, 32'h1);
    $display("test receive status done");
    apb(1'h1, A_DC, 32'h003f_0000); // enable all six types
    apb(1'h1, srxis_pkg::VEC_OFF, 32'ha8);
    apb(1'h1, A_CF, 32'h8);
    cnt <= 6'h03;
    pulse(13'h1204);
    `CHK("chain out while requesting", 1'h0, chain_out)
    chain_in <= 1'h0;
    srxis_host_model_inst.cyc(1'h1, 2'h0, 1'h0, 1'h0, 1'h0, r);
    `CHK("answer with chain low", 1'h0, r[8])
    chain_in <= 1'h1;
    ack_case(32'h8, 13'h0, 2'h0, 1'h0, 1'h0, 8'ha9);
    ack_case(32'h8, 13'h0, 2'h0, 1'h0, 1'h1, 8'haa);
    ack_case(32'h4, 13'h0, 2'h0, 1'h1, 1'h0, 8'had);
    ack_case(32'h9, 13'h0800, 2'h1, 1'h0, 1'h0, 8'hac);
    ack_case(32'hb, 13'h0200, 2'h3, 1'h0, 1'h0, 8'haa);
    apb(1'h1, A_CF, 32'h8);
    srxis_host_model_inst.cyc(1'h0, 2'h0, 1'h0, 1'h0, 1'h1, r);
    `CHK("wait in read", 1'h0, r[9])
    `CHK("read seen", 1'h1, r[10])
    srxis_host_model_inst.cyc(1'h0, 2'h0, 1'h0, 1'h0, 1'h0, r);
    `CHK("wait in write", 1'h0, r[9])
    `CHK("write seen", 1'h1, r[11])
    `CHK("chain out idle", 1'h1, chain_out)
    $display("test acknowledge done");
    close_out();
  end
endmodule
